// [hdl/srd_top.sv]
// Direction control for a two-port serial line repeater
`timescale 1ns/1ps
`default_nettype none
`include "srd_defs.svh"
module srd_top
   import srd_pkg::*;
#(
   parameter int CLK_HZ       = `SRD_CLK_HZ,   // Lower in simulation to shorten timeouts
   parameter int FLASH_CYCLES = `SRD_CLK_HZ / `SRD_MS_PER_S * `SRD_FLASH_MS
)(
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic [2:0] rate_select_switch,   // Line rate code
   input  wire logic [1:0] frame_length_switch,  // Frame bits minus nine
   input  wire logic       four_wire_mode,       // High: full duplex pairs
   input  wire logic       m_bus_in,             // Master two-wire pair, receive
   output logic            m_bus_out_q,          // Master two-wire pair, drive level
   output logic            m_bus_oe_q,           // Master two-wire pair, driver on
   input  wire logic       s_bus_in,             // Slave two-wire pair, receive
   output logic            s_bus_out_q,
   output logic            s_bus_oe_q,
   input  wire logic       m_rx,                 // Master receive pair (four-wire)
   output logic            m_tx_q,               // Master transmit pair (four-wire)
   input  wire logic       s_rx,                 // Slave receive pair (four-wire)
   output logic            s_tx_q,               // Slave transmit pair (four-wire)
   input  wire logic       drv_ready,            // Line drivers may take a new level
   output logic            red_led_q,            // Master traffic flash
   output logic            slave_led_q,          // Slave traffic flash
   output logic            power_led_q           // Steady while powered
);
   // -----------------------------------------------------------------------------
   // Timing helpers
   // -----------------------------------------------------------------------------
   // Cycles per bit for a rate code; rounds down, the line tolerates it
   function automatic int bit_cycles(input logic [2:0] code);
      int baud;
      unique case (code)
         `SRD_RATE_1200:   baud = `SRD_BAUD_1200;
         `SRD_RATE_2400:   baud = `SRD_BAUD_2400;
         `SRD_RATE_4800:   baud = `SRD_BAUD_4800;
         `SRD_RATE_9600:   baud = `SRD_BAUD_9600;
         `SRD_RATE_19200:  baud = `SRD_BAUD_19200;
         `SRD_RATE_38400:  baud = `SRD_BAUD_38400;
         `SRD_RATE_57600:  baud = `SRD_BAUD_57600;
         `SRD_RATE_115200: baud = `SRD_BAUD_115200;
      endcase
      return (CLK_HZ / baud < 1) ? 1 : CLK_HZ / baud;
   endfunction : bit_cycles

   // Whole-frame hold time for the current switch settings
   function automatic logic [`SRD_TMR_W-1:0] frame_cycles(input logic [2:0] rate,
                                                          input logic [1:0] len);
      int bits;
      bits = `SRD_FRAME_MIN + int'(len);
      return `SRD_TMR_W'(bits * bit_cycles(rate));
   endfunction : frame_cycles

   // -----------------------------------------------------------------------------
   // Input sampling and start-bit detection
   // -----------------------------------------------------------------------------
   logic                  m_lvl;       // Master level for the active wiring
   logic                  s_lvl;
   logic                  m_prev_q;    // Last sampled level, idle high
   logic                  s_prev_q;
   logic                  fall_m;      // Falling edge: start bit (or data edge)
   logic                  fall_s;
   logic [`SRD_TMR_W-1:0] load_c;      // Timer reload for current switches

   assign m_lvl  = four_wire_mode ? m_rx : m_bus_in;
   assign s_lvl  = four_wire_mode ? s_rx : s_bus_in;
   assign fall_m = m_prev_q && !m_lvl;
   assign fall_s = s_prev_q && !s_lvl;
   assign load_c = frame_cycles(rate_select_switch, frame_length_switch);

   // Previous levels for edge detection
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         m_prev_q <= `SRD_IDLE_LVL;
         s_prev_q <= `SRD_IDLE_LVL;
      end else begin
         m_prev_q <= m_lvl;
         s_prev_q <= s_lvl;
      end
   end

   // -----------------------------------------------------------------------------
   // Direction state machine
   // -----------------------------------------------------------------------------
   srd_dir_t              st_q;        // Current relay direction
   srd_dir_t              st_d;
   logic [`SRD_TMR_W-1:0] tmr_q;       // Cycles left before the driver is released
   logic [`SRD_TMR_W-1:0] tmr_d;

   // Next direction; the first port to show a start bit owns the bus
   always_comb begin
      st_d  = st_q;
      tmr_d = tmr_q;
      if (four_wire_mode) begin
         // Both pairs run at once, nothing to turn around
         st_d  = SRD_IDLE;
         tmr_d = '0;
      end else begin
         unique case (st_q)
            SRD_IDLE: begin
               // Master wins a tie; both sides talking at once is a bus fault
               if (fall_m) begin
                  st_d  = SRD_M2S;
                  tmr_d = load_c;
               end else if (fall_s) begin
                  st_d  = SRD_S2M;
                  tmr_d = load_c;
               end
            end
            SRD_M2S, SRD_S2M: begin
               // Own side edges keep the driver; far side is our echo
               if ((st_q == SRD_M2S) ? fall_m : fall_s) begin
                  tmr_d = load_c;
               end else if (tmr_q <= `SRD_TMR_W'(1)) begin
                  st_d  = SRD_IDLE;
                  tmr_d = '0;
               end else begin
                  tmr_d = tmr_q - `SRD_TMR_W'(1);
               end
            end
            default: begin
               st_d  = SRD_IDLE;
               tmr_d = '0;
            end
         endcase
      end
   end

   // Direction registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q  <= SRD_IDLE;
         tmr_q <= '0;
      end else begin
         st_q  <= st_d;
         tmr_q <= tmr_d;
      end
   end

   // -----------------------------------------------------------------------------
   // Data path through the two-entry buffer
   // -----------------------------------------------------------------------------
   // The sample stage holds its word while the buffer is full, so a driver
   // stall costs latency, not a word. A long stall does distort bit timing.
   logic [`SRD_BUF_W-1:0] smp_q;       // {master level, slave level}
   logic [`SRD_BUF_W-1:0] smp_d;
   logic                  buf_in_rdy;
   logic                  buf_out_vld;
   logic [`SRD_BUF_W-1:0] buf_out;
   logic                  m_out_d;
   logic                  s_out_d;
   logic                  m_oe_d;
   logic                  s_oe_d;
   logic                  m_tx_d;
   logic                  s_tx_d;

   srd_buf srd_buf_i (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_valid  (1'b1),
      .in_ready  (buf_in_rdy),
      .in_data   (smp_q),
      .out_valid (buf_out_vld),
      .out_ready (drv_ready),
      .out_data  (buf_out)
   );

   // Next driver levels; a drained word updates the lines
   always_comb begin
      smp_d   = buf_in_rdy ? {m_lvl, s_lvl} : smp_q;
      m_out_d = m_bus_out_q;
      s_out_d = s_bus_out_q;
      m_tx_d  = m_tx_q;
      s_tx_d  = s_tx_q;
      if (buf_out_vld && drv_ready) begin
         s_out_d = buf_out[1];
         m_out_d = buf_out[0];
         s_tx_d  = four_wire_mode ? buf_out[1] : `SRD_IDLE_LVL;
         m_tx_d  = four_wire_mode ? buf_out[0] : `SRD_IDLE_LVL;
      end
      s_oe_d = (st_d == SRD_M2S);
      m_oe_d = (st_d == SRD_S2M);
   end

   // Driver registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         smp_q       <= {`SRD_BUF_W{`SRD_IDLE_LVL}};
         m_bus_out_q <= `SRD_IDLE_LVL;
         s_bus_out_q <= `SRD_IDLE_LVL;
         m_bus_oe_q  <= 1'b0;
         s_bus_oe_q  <= 1'b0;
         m_tx_q      <= `SRD_IDLE_LVL;
         s_tx_q      <= `SRD_IDLE_LVL;
      end else begin
         smp_q       <= smp_d;
         m_bus_out_q <= m_out_d;
         s_bus_out_q <= s_out_d;
         m_bus_oe_q  <= m_oe_d;
         s_bus_oe_q  <= s_oe_d;
         m_tx_q      <= m_tx_d;
         s_tx_q      <= s_tx_d;
      end
   end

   // -----------------------------------------------------------------------------
   // Indicators
   // -----------------------------------------------------------------------------
   logic [`SRD_TMR_W-1:0] red_cnt_q;   // Remaining red flash time
   logic [`SRD_TMR_W-1:0] red_cnt_d;
   logic [`SRD_TMR_W-1:0] grn_cnt_q;   // Remaining slave flash time
   logic [`SRD_TMR_W-1:0] grn_cnt_d;
   logic                  act_m;       // Master start that is not our own echo
   logic                  act_s;       // Slave start that is not our own echo

   // A driven port reads back our own levels; only the talking side may flash
   assign act_m = fall_m && (st_q != SRD_S2M);
   assign act_s = fall_s && (st_q != SRD_M2S);

   // Each start edge restarts a fixed flash so short frames stay visible
   always_comb begin
      red_cnt_d = act_m ? `SRD_TMR_W'(FLASH_CYCLES)
                : (red_cnt_q != '0) ? red_cnt_q - `SRD_TMR_W'(1) : red_cnt_q;
      grn_cnt_d = act_s ? `SRD_TMR_W'(FLASH_CYCLES)
                : (grn_cnt_q != '0) ? grn_cnt_q - `SRD_TMR_W'(1) : grn_cnt_q;
   end

   // Indicator registers; power lamp is lit from reset onward
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         red_cnt_q   <= '0;
         grn_cnt_q   <= '0;
         red_led_q   <= 1'b0;
         slave_led_q <= 1'b0;
         power_led_q <= 1'b1;
      end else begin
         red_cnt_q   <= red_cnt_d;
         grn_cnt_q   <= grn_cnt_d;
         red_led_q   <= (red_cnt_d != '0);
         slave_led_q <= (grn_cnt_d != '0);
         power_led_q <= 1'b1;
      end
   end

   // -----------------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------------
   master_turn_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !four_wire_mode && st_q == SRD_IDLE && fall_m |=> s_bus_oe_q && !m_bus_oe_q)
      else $error("master start did not enable slave driver");
   duplex_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
      four_wire_mode && $past(four_wire_mode) |-> !m_bus_oe_q && !s_bus_oe_q)
      else $error("two-wire driver on in four-wire mode");
   rate_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !four_wire_mode && st_q == SRD_IDLE && fall_s |=> tmr_q == $past(load_c))
      else $error("timer not loaded from rate and length");
   frame_len_a: assert property (@(posedge mclk) disable iff (!reset_n)
      load_c == `SRD_TMR_W'((`SRD_FRAME_MIN + int'(frame_length_switch))
                            * bit_cycles(rate_select_switch)))
      else $error("frame time not bits times bit period");
   default_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
      rate_select_switch == `SRD_RATE_9600 && frame_length_switch == `SRD_FRAME_10
      |-> load_c == `SRD_TMR_W'(`SRD_FRAME_DEF_BITS * (CLK_HZ / `SRD_BAUD_9600)))
      else $error("factory setting timing wrong");
   red_flash_a: assert property (@(posedge mclk) disable iff (!reset_n)
      act_m |=> red_led_q [*2]) else $error("red lamp missed master traffic");
   slave_flash_a: assert property (@(posedge mclk) disable iff (!reset_n)
      act_s |=> slave_led_q && power_led_q) else $error("slave lamp missed traffic");
   release_time_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !four_wire_mode && st_q == SRD_M2S && tmr_q == `SRD_TMR_W'(1) && !fall_m
      |=> st_q == SRD_IDLE && !s_bus_oe_q)
      else $error("driver not released after frame time");
   echo_block_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !four_wire_mode && st_q == SRD_M2S && fall_s && !fall_m && tmr_q > `SRD_TMR_W'(1)
      |=> st_q == SRD_M2S && tmr_q == $past(tmr_q) - `SRD_TMR_W'(1))
      else $error("echo on driven port disturbed direction");
endmodule : srd_top
`default_nettype wire

// [hdl/srd_defs.svh]
// Constants for the serial repeater direction control block
`ifndef SRD_DEFS_SVH
`define SRD_DEFS_SVH
// -----------------------------------------------------------------------------
// Clock and timing
// -----------------------------------------------------------------------------
`define SRD_CLK_HZ        10000000
`define SRD_FLASH_MS      20
`define SRD_MS_PER_S      1000
// -----------------------------------------------------------------------------
// Switch encodings
// -----------------------------------------------------------------------------
`define SRD_RATE_1200     3'h0
`define SRD_RATE_2400     3'h1
`define SRD_RATE_4800     3'h2
`define SRD_RATE_9600     3'h3
`define SRD_RATE_19200    3'h4
`define SRD_RATE_38400    3'h5
`define SRD_RATE_57600    3'h6
`define SRD_RATE_115200   3'h7
`define SRD_BAUD_1200     1200
`define SRD_BAUD_2400     2400
`define SRD_BAUD_4800     4800
`define SRD_BAUD_9600     9600
`define SRD_BAUD_19200    19200
`define SRD_BAUD_38400    38400
`define SRD_BAUD_57600    57600
`define SRD_BAUD_115200   115200
`define SRD_FRAME_MIN     9
`define SRD_FRAME_10      2'h1
`define SRD_FRAME_DEF_BITS 10
// -----------------------------------------------------------------------------
// Widths and reset values
// -----------------------------------------------------------------------------
`define SRD_TMR_W         24
`define SRD_BUF_W         2
`define SRD_IDLE_LVL      1'b1
`endif

// [hdl/srd_pkg.sv]
// Types shared by the serial repeater direction control block
`default_nettype none
package srd_pkg;
   // --------------------------------------------------------------------------
   // Relay direction
   // --------------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRD_IDLE,    // No traffic, both bus drivers off
      SRD_M2S,     // Master side talks, slave driver on
      SRD_S2M      // Slave side talks, master driver on
   } srd_dir_t;
endpackage : srd_pkg
`default_nettype wire

// [hdl/srd_buf.sv]
// Two-entry valid/ready buffer for the relayed line levels
`timescale 1ns/1ps
`default_nettype none
`include "srd_defs.svh"
module srd_buf
   import srd_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire logic                  in_valid,
   output logic                       in_ready,
   input  wire logic [`SRD_BUF_W-1:0] in_data,
   output logic                       out_valid,
   input  wire logic                  out_ready,
   output logic [`SRD_BUF_W-1:0]      out_data
);
   // -----------------------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------------------
   logic [`SRD_BUF_W-1:0] mem_q [2];   // Entry 0 is always the head
   logic [`SRD_BUF_W-1:0] mem_d [2];
   logic [1:0]            cnt_q;       // Entries held, 0..2
   logic [1:0]            cnt_d;
   logic                  push;
   logic                  pop;

   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[0];

   // Next state: shift on pop so the head stays in slot 0
   always_comb begin
      push     = in_valid && in_ready;
      pop      = out_valid && out_ready;
      mem_d[0] = mem_q[0];
      mem_d[1] = mem_q[1];
      cnt_d    = cnt_q;
      if (pop) begin
         mem_d[0] = mem_q[1];
      end
      if (push) begin
         // Lands behind whatever stays after the pop
         if ((cnt_q == 2'h0) || ((cnt_q == 2'h1) && pop)) begin
            mem_d[0] = in_data;
         end else begin
            mem_d[1] = in_data;
         end
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   // Registers; idle line level on reset so drivers start quiet
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mem_q[0] <= {`SRD_BUF_W{`SRD_IDLE_LVL}};
         mem_q[1] <= {`SRD_BUF_W{`SRD_IDLE_LVL}};
         cnt_q    <= 2'h0;
      end else begin
         mem_q[0] <= mem_d[0];
         mem_q[1] <= mem_d[1];
         cnt_q    <= cnt_d;
      end
   end

   // Never more than two entries
   buf_bound_a: assert property (@(posedge mclk) disable iff (!reset_n)
      cnt_q <= 2'h2) else $error("buffer count above two");
endmodule : srd_buf
`default_nettype wire

// [test/srd_node_model.sv]
// Behavioural bus nodes on the master and slave cable segments
`timescale 1ns/1ps
`default_nettype none
module srd_node_model (
   input  wire logic mclk,
   input  wire logic m_bus_out_q,
   input  wire logic m_bus_oe_q,
   input  wire logic s_bus_out_q,
   input  wire logic s_bus_oe_q,
   output logic      m_bus_in,
   output logic      s_bus_in,
   output logic      m_rx,
   output logic      s_rx
);
   // ---------------------------------------------------------------------
   // Node levels
   // ---------------------------------------------------------------------
   logic m_lvl    = 1'b1;  // Master node on the two-wire pair
   logic s_lvl    = 1'b1;  // Slave node on the two-wire pair
   logic m_rx_lvl = 1'b1;  // Master node transmit pair
   logic s_rx_lvl = 1'b1;  // Slave node transmit pair

   // Repeater driver wins while enabled; fail-safe bias pulls a free line high
   assign m_bus_in = m_bus_oe_q ? m_bus_out_q : m_lvl;
   assign s_bus_in = s_bus_oe_q ? s_bus_out_q : s_lvl;
   assign m_rx     = m_rx_lvl;
   assign s_rx     = s_rx_lvl;

   // One-cycle low glitch on either or both segments, changed at falling edges
   task automatic pulse(input logic on_m, input logic on_s);
      @(negedge mclk);
      if (on_m) m_lvl = 1'b0;
      if (on_s) s_lvl = 1'b0;
      @(negedge mclk);
      m_lvl = 1'b1;
      s_lvl = 1'b1;
   endtask : pulse

   // Whole character, start + 8 data LSB first + 1 stop, bc cycles a bit
   task automatic send_frame(input logic side, input logic [7:0] data, input int bc);
      logic [9:0] fr;
      fr = {1'b1, data, 1'b0};
      // Wait for a quiet segment so nothing already on the wire is lost
      do @(negedge mclk);
      while (side ? (s_bus_oe_q || !s_bus_in) : (m_bus_oe_q || !m_bus_in));
      for (int i = 0; i < 10; i++) begin
         for (int j = 0; j < bc; j++) begin
            if (side) s_lvl = fr[i];
            else m_lvl = fr[i];
            @(negedge mclk);
         end
      end
      m_lvl = 1'b1;
      s_lvl = 1'b1;
   endtask : send_frame
endmodule : srd_node_model
`default_nettype wire

// [test/serial_repeater_direction_control_test.sv]
// Self-checking bench for the repeater direction control
`timescale 1ns/1ps
`default_nettype none
`include "srd_defs.svh"
module serial_repeater_direction_control_test;
   // ---------------------------------------------------------------------
   // Setup and signals
   // ---------------------------------------------------------------------
   localparam int CLK_T   = 460800;  // Four cycles a bit at the top rate
   localparam int FLASH_T = 8;       // Short flash keeps runs brief
   typedef struct {logic [2:0] rate; logic [1:0] len; logic side; int hold;} srd_row_t;
   logic       mclk;
   logic       reset_n;
   logic [2:0] rate_sw;
   logic [1:0] len_sw;
   logic       four_wire;
   logic       drv_ready;
   logic       m_bus_in, m_bus_out_q, m_bus_oe_q, s_bus_in, s_bus_out_q, s_bus_oe_q;
   logic       m_rx, m_tx_q, s_rx, s_tx_q, red_led_q, slave_led_q, power_led_q;
   int         n_fail    = 0;
   int         cmp_count = 0;
   logic       mon_on    = 1'b0;  // Latency monitor armed
   logic [1:0] hm        = 2'h3;  // Master-side level history
   logic [1:0] hs        = 2'h3;  // Slave-side level history
   logic       m_oe_p    = 1'b0;
   logic       s_oe_p    = 1'b0;
   logic       echo2, bad;
   int         got;
   logic [15:0] pat = 16'hC35A;
   // Hold expected = frame bits times whole bit cycles, side 1 = slave talks
   srd_row_t rows [9] = '{
      '{`SRD_RATE_9600, `SRD_FRAME_10, 1'b0, 10 * (CLK_T / `SRD_BAUD_9600)},
      '{`SRD_RATE_1200, 2'h0, 1'b0, 9 * (CLK_T / `SRD_BAUD_1200)},
      '{`SRD_RATE_2400, 2'h3, 1'b1, 12 * (CLK_T / `SRD_BAUD_2400)},
      '{`SRD_RATE_4800, 2'h2, 1'b0, 11 * (CLK_T / `SRD_BAUD_4800)},
      '{`SRD_RATE_9600, 2'h1, 1'b1, 10 * (CLK_T / `SRD_BAUD_9600)},
      '{`SRD_RATE_19200, 2'h0, 1'b0, 9 * (CLK_T / `SRD_BAUD_19200)},
      '{`SRD_RATE_38400, 2'h1, 1'b1, 10 * (CLK_T / `SRD_BAUD_38400)},
      '{`SRD_RATE_57600, 2'h2, 1'b0, 11 * (CLK_T / `SRD_BAUD_57600)},
      '{`SRD_RATE_115200, 2'h3, 1'b1, 12 * (CLK_T / `SRD_BAUD_115200)}};

   srd_top #(.CLK_HZ(CLK_T), .FLASH_CYCLES(FLASH_T)) srd_top_i (
      .mclk(mclk), .reset_n(reset_n), .rate_select_switch(rate_sw),
      .frame_length_switch(len_sw), .four_wire_mode(four_wire),
      .m_bus_in(m_bus_in), .m_bus_out_q(m_bus_out_q), .m_bus_oe_q(m_bus_oe_q),
      .s_bus_in(s_bus_in), .s_bus_out_q(s_bus_out_q), .s_bus_oe_q(s_bus_oe_q),
      .m_rx(m_rx), .m_tx_q(m_tx_q), .s_rx(s_rx), .s_tx_q(s_tx_q), .drv_ready(drv_ready),
      .red_led_q(red_led_q), .slave_led_q(slave_led_q), .power_led_q(power_led_q));

   srd_node_model node_i (
      .mclk(mclk), .m_bus_out_q(m_bus_out_q), .m_bus_oe_q(m_bus_oe_q),
      .s_bus_out_q(s_bus_out_q), .s_bus_oe_q(s_bus_oe_q), .m_bus_in(m_bus_in),
      .s_bus_in(s_bus_in), .m_rx(m_rx), .s_rx(s_rx));

   // ---------------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask : end_test

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up

   // Count far-driver cycles of one relay; the near driver must never answer the echo
   task automatic measure(input logic side, input int exp_hold);
      int   hold;
      logic echo;
      logic oe;
      logic lamp;
      hold = 0;
      echo = 1'b0;
      lamp = 1'b0;
      for (int k = 0; k < 6000; k++) begin
         @(negedge mclk);
         oe   = side ? m_bus_oe_q : s_bus_oe_q;
         echo = echo | (side ? s_bus_oe_q : m_bus_oe_q);
         lamp = lamp | (side ? red_led_q : slave_led_q);
         if (oe === 1'b1) begin
            hold++;
            if (hold == 1) chk({red_led_q, slave_led_q, power_led_q}, side ? 3'h3 : 3'h5);
            if (hold == exp_hold) chk({red_led_q, slave_led_q}, 2'h0);
         end else if (hold > 0) break;
      end
      chk(hold, exp_hold);
      chk(echo, 1'b0);
      chk(lamp, 1'b0);
   endtask : measure

   // Relayed level must trail its source by two cycles on whichever path is live
   always begin
      @(posedge mclk);
      #10;
      if (mon_on && four_wire) chk({s_tx_q, m_tx_q}, {hm[1], hs[1]});
      if (mon_on && !four_wire && s_bus_oe_q && s_oe_p) chk(s_bus_out_q, hm[1]);
      if (mon_on && !four_wire && m_bus_oe_q && m_oe_p) chk(m_bus_out_q, hs[1]);
      hm     = {hm[0], four_wire ? m_rx : m_bus_in};
      hs     = {hs[0], four_wire ? s_rx : s_bus_in};
      m_oe_p = m_bus_oe_q;
      s_oe_p = s_bus_oe_q;
   end

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Watchdog sized at about three and a half times the expected run
   initial begin
      repeat (30000) @(posedge mclk);
      n_fail++;
      $display("watchdog expired");
      wrap_up();
   end

   // ---------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      rate_sw = `SRD_RATE_9600;
      len_sw = `SRD_FRAME_10;
      four_wire = 1'b0;
      drv_ready = 1'b1;
      repeat (10) @(negedge mclk);
      reset_n = 1'b1;
      repeat (2) @(negedge mclk);
      mon_on = 1'b1;
      // Ordinary relays: every rate code, every frame length, both directions
      for (int r = 0; r < 9; r++) begin
         @(negedge mclk);
         rate_sw = rows[r].rate;
         len_sw = rows[r].len;
         fork
            node_i.pulse(!rows[r].side, rows[r].side);
            measure(rows[r].side, rows[r].hold);
         join
      end
      end_test("rows");
      // Characters of 1+8+0+1 bits need the ten-bit setting, four cycles a bit
      len_sw = `SRD_FRAME_10;
      // Whole characters: each later falling edge restarts the hold
      fork
         node_i.send_frame(1'b0, 8'h55, 4);
         measure(1'b0, 8 * 4 + 40);
      join
      fork
         node_i.send_frame(1'b1, 8'hA3, 4);
         measure(1'b1, 7 * 4 + 40);
      join
      end_test("frames");
      // Both sides start together: master side takes the bus
      node_i.pulse(1'b1, 1'b1);
      @(negedge mclk);
      chk({m_bus_oe_q, s_bus_oe_q}, 2'h1);
      repeat (50) @(negedge mclk);
      chk({m_bus_oe_q, s_bus_oe_q}, 2'h0);
      end_test("tie");
      // Full duplex: both pairs at once, direction logic stays out
      @(negedge mclk);
      four_wire = 1'b1;
      echo2 = 1'b0;
      for (int i = 0; i < 20; i++) begin
         @(negedge mclk);
         node_i.m_rx_lvl = (i < 16) ? pat[i] : 1'b1;
         node_i.s_rx_lvl = (i < 16) ? pat[15-i] : 1'b1;
         node_i.m_lvl = (i < 16) ? pat[i] : 1'b1;
         echo2 = echo2 | m_bus_oe_q | s_bus_oe_q;
      end
      chk(echo2, 1'b0);
      end_test("four_wire");
      // Stalled drivers hold the last level, then drain ones before zeros
      mon_on = 1'b0;
      @(negedge mclk);
      drv_ready = 1'b0;
      node_i.m_rx_lvl = 1'b0;
      for (int i = 0; i < 6; i++) begin
         @(negedge mclk);
         chk(s_tx_q, 1'b1);
      end
      drv_ready = 1'b1;
      got = 0;
      bad = 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(negedge mclk);
         if (s_tx_q === 1'b0) got++;
         else if (got > 0) bad = 1'b1;
      end
      chk({got > 0, bad}, 2'h2);
      node_i.m_rx_lvl = 1'b1;
      four_wire = 1'b0;
      repeat (4) @(negedge mclk);
      end_test("stall");
      // Reset in mid-relay drops every driver and flash at once
      node_i.pulse(1'b1, 1'b0);
      repeat (2) @(negedge mclk);
      reset_n = 1'b0;
      @(negedge mclk);
      chk({m_bus_out_q, s_bus_out_q, m_tx_q, s_tx_q, m_bus_oe_q, s_bus_oe_q,
           red_led_q, slave_led_q, power_led_q}, 9'h1E1);
      reset_n = 1'b1;
      @(negedge mclk);
      chk({m_bus_out_q, s_bus_out_q, m_tx_q, s_tx_q, m_bus_oe_q, s_bus_oe_q,
           red_led_q, slave_led_q, power_led_q}, 9'h1E1);
      end_test("reset");
      wrap_up();
   end
endmodule : serial_repeater_direction_control_test
`default_nettype wire
